//--- verilog/rdit_defines.vh
`ifndef RDIT_DEFINES_VH
`define RDIT_DEFINES_VH

// ---------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ---------------------------------------------------------------
`define RDIT_OFF_STATE_LOW    8'h00
`define RDIT_OFF_STATE_HIGH   8'h04
`define RDIT_OFF_ACK_WAIT     8'h08
`define RDIT_OFF_CHG_GUARD    8'h0C
`define RDIT_OFF_GEN_CTRL     8'h10
`define RDIT_OFF_HOLDOFF      8'h14
`define RDIT_OFF_TYPE_MASK    8'h18
`define RDIT_OFF_PORT_MASK    8'h1C
`define RDIT_OFF_PENDING      8'h20
`define RDIT_OFF_RTR_CFG      8'h24
`define RDIT_OFF_PORT_CTRL    8'h28
`define RDIT_OFF_PORT_STS0    8'h30

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RDIT_GEN_EN_BIT       0
`define RDIT_GEN_LEVEL_BIT    1
`define RDIT_GEN_HOLD_BIT     2
`define RDIT_GEN_CLRACK_BIT   3
`define RDIT_GEN_CLREXP_BIT   4
`define RDIT_GEN_RUNEV_BIT    5
`define RDIT_GEN_NUM_LSB      8
`define RDIT_CFG_CHG_BIT      0
`define RDIT_CFG_EXT_BIT      1
`define RDIT_CFG_AUXT_BIT     2
`define RDIT_CFG_AUXI_BIT     3
`define RDIT_CFG_SPILLME_BIT  4
`define RDIT_CODE_FLAGS       2'h2

// ---------------------------------------------------------------
// Sizes and reset values
// ---------------------------------------------------------------
`define RDIT_NPORT            4
`define RDIT_NERR             6
`define RDIT_TW               16
`define RDIT_RST_TIMER        16'h0000
`define RDIT_RST_WORD         32'h00000000

`endif

//--- verilog/rdit_num_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "rdit_defines.vh"

module rdit_num_timer (
    input  wire                    clk,
    input  wire                    rst_b,
    input  wire                    load,
    input  wire                    stop,
    input  wire [`RDIT_TW-1:0]     reload,
    output wire                    running,
    output wire                    expire
);
    reg  [`RDIT_TW-1:0] cnt_q;
    reg                 run_q;

    // Counts down once per cycle; expire pulses at count one, a zero reload never runs
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= `RDIT_RST_TIMER;
            run_q <= 1'b0;
        end else if (load) begin
            cnt_q <= reload;
            run_q <= (reload != `RDIT_RST_TIMER);
        end else if (stop) begin
            run_q <= 1'b0;
        end else if (run_q) begin
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q == 16'h0001)
                run_q <= 1'b0;
        end
    end

    assign running = run_q;
    assign expire  = run_q && (cnt_q == 16'h0001) && !load && !stop;
endmodule
`default_nettype wire

//--- verilog/rdit_top.v
`timescale 1ns/1ps
`default_nettype none
`include "rdit_defines.vh"

module rdit_top (
    input  wire                           REF_CLK,
    input  wire                           RST_B,
    input  wire [7:0]                     REG_ADDR,
    input  wire [31:0]                    REG_WDATA,
    input  wire                           REG_WR,
    input  wire                           REG_RD,
    output reg  [31:0]                    REG_RDATA,
    input  wire                           RX_CODE_VALID,
    input  wire [7:0]                     RX_CODE,
    input  wire                           RX_CODE_AUX,
    input  wire [`RDIT_NPORT-1:0]         RX_PORT_TRUNC_ON,
    input  wire [`RDIT_NPORT-1:0]         PKT_ONGOING,
    input  wire [`RDIT_NPORT-1:0]         CODE_FILTER_PASS,
    input  wire [`RDIT_NPORT*`RDIT_NERR-1:0] ERR_EVENT,
    input  wire [`RDIT_NPORT-1:0]         RUN_ENTER,
    input  wire                           TABLE_MEM_ERR,
    input  wire                           FIFO_MEM_ERR,
    input  wire                           TX_CODE_READY,
    output reg                            TX_CODE_VALID,
    output reg  [7:0]                     TX_CODE,
    output reg                            AUX_TX_VALID,
    output reg  [7:0]                     AUX_TX_CODE,
    output reg  [5:0]                     TIME_COUNT,
    output reg  [`RDIT_NPORT-1:0]         PKT_SPILL,
    output reg                            PKT_DISCARD,
    output reg                            FIFO_SPILL
);
    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    reg  [63:0]                     state_q;
    reg  [63:0]                     state_d;
    reg  [`RDIT_TW-1:0]             ack_wait_reload_q;
    reg  [`RDIT_TW-1:0]             change_guard_reload_q;
    reg  [`RDIT_TW-1:0]             ack_holdoff_reload_q;
    reg  [15:0]                     code_gen_control_q;
    reg  [`RDIT_NERR-1:0]           error_type_mask_q;
    reg  [`RDIT_NPORT-1:0]          port_error_mask_q;
    reg  [`RDIT_NPORT-1:0]          pending_error_flags_q;
    reg  [`RDIT_NPORT-1:0]          pending_error_flags_d;
    reg  [7:0]                      rtr_cfg_q;
    reg  [`RDIT_NPORT*`RDIT_NERR-1:0] port_error_status_q;
    reg                             held_q;
    reg                             gen_src_q;
    reg  [`RDIT_NPORT-1:0]          gen_flags_q;
    reg  [`RDIT_TW-1:0]             holdoff_q;

    wire [63:0]                     aw_run;
    wire [63:0]                     aw_exp;
    wire [63:0]                     cg_run;
    wire [63:0]                     aw_load;
    wire [63:0]                     aw_stop;
    wire [63:0]                     cg_load;

    wire change_guard_enable = rtr_cfg_q[`RDIT_CFG_CHG_BIT];
    wire extended_irq_mode   = rtr_cfg_q[`RDIT_CFG_EXT_BIT];
    wire aux_time_enable     = rtr_cfg_q[`RDIT_CFG_AUXT_BIT];
    wire aux_irq_enable      = rtr_cfg_q[`RDIT_CFG_AUXI_BIT];
    wire spill_on_mem_error  = rtr_cfg_q[`RDIT_CFG_SPILLME_BIT];
    wire code_gen_enable     = code_gen_control_q[`RDIT_GEN_EN_BIT];
    wire gen_level_select    = code_gen_control_q[`RDIT_GEN_LEVEL_BIT];
    wire ack_holdoff_enable  = code_gen_control_q[`RDIT_GEN_HOLD_BIT];
    wire clear_on_ack        = code_gen_control_q[`RDIT_GEN_CLRACK_BIT];
    wire clear_on_expiry     = code_gen_control_q[`RDIT_GEN_CLREXP_BIT];
    wire run_event_enable    = code_gen_control_q[`RDIT_GEN_RUNEV_BIT];
    wire [4:0] gen_irq_number = code_gen_control_q[`RDIT_GEN_NUM_LSB+4:`RDIT_GEN_NUM_LSB];

    // ---------------------------------------------------------------
    // Code decode
    // ---------------------------------------------------------------
    // Maps a code to its status index; bit5 selects upper half only
    // in extended mode
    function [5:0] code_index;
        input [7:0] code;
        input       ext;
        begin
            code_index = {ext & code[5], code[4:0]};
        end
    endfunction

    function is_ack;
        input [7:0] code;
        input       ext;
        begin
            is_ack = code[5] & ~ext;
        end
    endfunction

    wire       rx_irq   = RX_CODE_VALID && (RX_CODE[7:6] == `RDIT_CODE_FLAGS) &&
                          (!RX_CODE_AUX || aux_irq_enable);
    wire       rx_time  = RX_CODE_VALID && (RX_CODE[7:6] == 2'h0) &&
                          (!RX_CODE_AUX || aux_time_enable);
    wire [5:0] rx_idx   = code_index(RX_CODE, extended_irq_mode);
    wire       rx_ack   = is_ack(RX_CODE, extended_irq_mode);
    wire       rx_guard = change_guard_enable && cg_run[rx_idx];
    wire       rx_flip  = rx_irq && !rx_guard && (rx_ack ? state_q[rx_idx] : !state_q[rx_idx]);
    wire       rx_tvalid = rx_time && (RX_CODE[5:0] == TIME_COUNT + 6'h01);

    // Generated code (interrupt form, number from control field)
    wire [5:0] gen_idx     = {1'b0, gen_irq_number};
    wire [7:0] gen_code    = {`RDIT_CODE_FLAGS, 1'b0, gen_irq_number};
    wire       gen_allowed = !state_q[gen_idx] && !(change_guard_enable && cg_run[gen_idx]) &&
                             (holdoff_q == `RDIT_RST_TIMER) && TX_CODE_READY &&
                             !(rx_irq && rx_idx == gen_idx);
    wire       gen_send    = held_q && gen_allowed && (pending_error_flags_q != 4'h0);
    wire       own_ack     = rx_flip && rx_ack && gen_src_q && (rx_idx == gen_idx);

    // ---------------------------------------------------------------
    // Per-number timers
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 64; gi = gi + 1) begin : g_num
            assign aw_load[gi] = (rx_flip && !rx_ack && rx_idx == gi) ||
                                 (gen_send && gen_idx == gi);
            assign aw_stop[gi] = rx_flip && rx_ack && rx_idx == gi;
            assign cg_load[gi] = change_guard_enable && (aw_load[gi] || aw_stop[gi]);
            rdit_num_timer u_ack_wait (
                .clk     (REF_CLK),
                .rst_b   (RST_B),
                .load    (aw_load[gi]),
                .stop    (aw_stop[gi]),
                .reload  (ack_wait_reload_q),
                .running (aw_run[gi]),
                .expire  (aw_exp[gi])
            );
            rdit_num_timer u_chg_guard (
                .clk     (REF_CLK),
                .rst_b   (RST_B),
                .load    (cg_load[gi]),
                .stop    (1'b0),
                .reload  (change_guard_reload_q),
                .running (cg_run[gi]),
                .expire  ()
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // Error events and pending flags
    // ---------------------------------------------------------------
    integer p;
    reg  [`RDIT_NPORT-1:0] port_hit;
    always @* begin
        for (p = 0; p < `RDIT_NPORT; p = p + 1)
            port_hit[p] = (|(ERR_EVENT[p*`RDIT_NERR +: `RDIT_NERR] & error_type_mask_q)) ||
                          (run_event_enable && RUN_ENTER[p]);
        port_hit = port_hit & port_error_mask_q;
    end

    wire gen_clear = (own_ack && clear_on_ack) ||
                     (gen_src_q && aw_exp[gen_idx] && clear_on_expiry);
    wire pend_wr   = REG_WR && (REG_ADDR == `RDIT_OFF_PENDING);

    always @* begin
        pending_error_flags_d = pending_error_flags_q;
        if (pend_wr)
            pending_error_flags_d = pending_error_flags_d & ~REG_WDATA[`RDIT_NPORT-1:0];
        if (gen_clear)
            pending_error_flags_d = pending_error_flags_d & ~gen_flags_q;
        pending_error_flags_d = pending_error_flags_d | (code_gen_enable ? port_hit : 4'h0);
    end

    // Status bits: all sources merged in one cycle
    always @* begin
        state_d = state_q;
        if (REG_WR && REG_ADDR == `RDIT_OFF_STATE_LOW)
            state_d[31:0] = state_d[31:0] & ~REG_WDATA;
        if (REG_WR && REG_ADDR == `RDIT_OFF_STATE_HIGH)
            state_d[63:32] = state_d[63:32] & ~REG_WDATA;
        state_d = state_d & ~aw_exp;
        if (rx_flip)
            state_d[rx_idx] = !rx_ack;
        if (gen_send)
            state_d[gen_idx] = 1'b1;
    end

    // ---------------------------------------------------------------
    // Sequential state
    // ---------------------------------------------------------------
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q               <= 64'h0000000000000000;
            ack_wait_reload_q     <= `RDIT_RST_TIMER;
            change_guard_reload_q <= `RDIT_RST_TIMER;
            ack_holdoff_reload_q  <= `RDIT_RST_TIMER;
            code_gen_control_q    <= 16'h0000;
            error_type_mask_q     <= 6'h00;
            port_error_mask_q     <= 4'h0;
            pending_error_flags_q <= 4'h0;
            rtr_cfg_q             <= 8'h00;
            port_error_status_q   <= 24'h000000;
            held_q                <= 1'b0;
            gen_src_q             <= 1'b0;
            gen_flags_q           <= 4'h0;
            holdoff_q             <= `RDIT_RST_TIMER;
            TX_CODE_VALID         <= 1'b0;
            TX_CODE               <= 8'h00;
            AUX_TX_VALID          <= 1'b0;
            AUX_TX_CODE           <= 8'h00;
            TIME_COUNT            <= 6'h00;
            PKT_SPILL             <= 4'h0;
            PKT_DISCARD           <= 1'b0;
            FIFO_SPILL            <= 1'b0;
            REG_RDATA             <= `RDIT_RST_WORD;
        end else begin
            state_q               <= state_d;
            pending_error_flags_q <= pending_error_flags_d;
            if (REG_WR) begin
                case (REG_ADDR)
                    `RDIT_OFF_ACK_WAIT:  ack_wait_reload_q     <= REG_WDATA[`RDIT_TW-1:0];
                    `RDIT_OFF_CHG_GUARD: change_guard_reload_q <= REG_WDATA[`RDIT_TW-1:0];
                    `RDIT_OFF_HOLDOFF:   ack_holdoff_reload_q  <= REG_WDATA[`RDIT_TW-1:0];
                    `RDIT_OFF_GEN_CTRL:  code_gen_control_q    <= REG_WDATA[15:0];
                    `RDIT_OFF_TYPE_MASK: error_type_mask_q     <= REG_WDATA[`RDIT_NERR-1:0];
                    `RDIT_OFF_PORT_MASK: port_error_mask_q     <= REG_WDATA[`RDIT_NPORT-1:0];
                    `RDIT_OFF_RTR_CFG:   rtr_cfg_q             <= REG_WDATA[7:0];
                    default: ;
                endcase
            end
            // Sticky error status, set beats clear
            if (REG_WR && REG_ADDR == `RDIT_OFF_PORT_STS0)
                port_error_status_q <= (port_error_status_q & ~REG_WDATA[23:0]) | ERR_EVENT;
            else
                port_error_status_q <= port_error_status_q | ERR_EVENT;

            // Edge mode arms on a fresh rise only; level keeps it armed
            if (gen_send)
                held_q <= (gen_level_select || (|(pending_error_flags_d & ~pending_error_flags_q))) &&
                          (pending_error_flags_d != 4'h0);
            else if (pending_error_flags_d == 4'h0)
                held_q <= 1'b0;
            else if (gen_level_select || (|(pending_error_flags_d & ~pending_error_flags_q)))
                held_q <= 1'b1;

            if (gen_send) begin
                gen_src_q   <= 1'b1;
                gen_flags_q <= pending_error_flags_q;
            end else if (own_ack || aw_exp[gen_idx]) begin
                gen_src_q   <= 1'b0;
            end

            // Holdoff timer counts down to zero
            if (own_ack && ack_holdoff_enable)
                holdoff_q <= ack_holdoff_reload_q;
            else if (holdoff_q != `RDIT_RST_TIMER)
                holdoff_q <= holdoff_q - 16'h0001;

            // Outgoing codes; received codes win the port this cycle
            TX_CODE_VALID <= rx_flip || rx_tvalid || gen_send;
            TX_CODE       <= (rx_flip || rx_tvalid) ? RX_CODE : gen_code;
            AUX_TX_VALID  <= ((rx_flip && aux_irq_enable) || (rx_tvalid && aux_time_enable) ||
                              (gen_send && aux_irq_enable)) && !(RX_CODE_AUX && (rx_flip || rx_tvalid));
            AUX_TX_CODE   <= (rx_flip || rx_tvalid) ? RX_CODE : gen_code;
            if (rx_time)
                TIME_COUNT <= RX_CODE[5:0];

            PKT_SPILL   <= RX_PORT_TRUNC_ON & PKT_ONGOING & CODE_FILTER_PASS &
                           {`RDIT_NPORT{rx_flip || rx_tvalid}};
            PKT_DISCARD <= TABLE_MEM_ERR;
            FIFO_SPILL  <= FIFO_MEM_ERR && spill_on_mem_error;

            // Read data in the next cycle only; unmapped reads zero
            REG_RDATA <= `RDIT_RST_WORD;
            if (REG_RD) begin
                case (REG_ADDR)
                    `RDIT_OFF_STATE_LOW:  REG_RDATA <= state_q[31:0];
                    `RDIT_OFF_STATE_HIGH: REG_RDATA <= state_q[63:32];
                    `RDIT_OFF_ACK_WAIT:   REG_RDATA <= {16'h0000, ack_wait_reload_q};
                    `RDIT_OFF_CHG_GUARD:  REG_RDATA <= {16'h0000, change_guard_reload_q};
                    `RDIT_OFF_HOLDOFF:    REG_RDATA <= {16'h0000, ack_holdoff_reload_q};
                    `RDIT_OFF_GEN_CTRL:   REG_RDATA <= {16'h0000, code_gen_control_q};
                    `RDIT_OFF_TYPE_MASK:  REG_RDATA <= {26'h0000000, error_type_mask_q};
                    `RDIT_OFF_PORT_MASK:  REG_RDATA <= {28'h0000000, port_error_mask_q};
                    `RDIT_OFF_PENDING:    REG_RDATA <= {28'h0000000, pending_error_flags_q};
                    `RDIT_OFF_RTR_CFG:    REG_RDATA <= {24'h000000, rtr_cfg_q};
                    `RDIT_OFF_PORT_STS0:  REG_RDATA <= {8'h00, port_error_status_q};
                    default:              REG_RDATA <= `RDIT_RST_WORD;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- bench/rdit_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rdit_monitor (
    input wire logic       REF_CLK,
    input wire logic       RST_B,
    input wire logic       RX_CODE_VALID,
    input wire logic [7:0] RX_CODE,
    input wire logic       RX_CODE_AUX,
    input wire logic [3:0] RX_PORT_TRUNC_ON,
    input wire logic [3:0] PKT_ONGOING,
    input wire logic [3:0] CODE_FILTER_PASS,
    input wire logic       TABLE_MEM_ERR,
    input wire logic       FIFO_MEM_ERR,
    input wire logic       TX_CODE_VALID,
    input wire logic [7:0] TX_CODE,
    input wire logic       AUX_TX_VALID,
    input wire logic [7:0] AUX_TX_CODE,
    input wire logic [5:0] TIME_COUNT,
    input wire logic [3:0] PKT_SPILL,
    input wire logic       PKT_DISCARD,
    input wire logic       FIFO_SPILL
);
    // ----------------------------------------
    // Helper: ports armed for truncation
    // ----------------------------------------
    logic [3:0] arm_q;
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B)
            arm_q <= 4'h0;
        else
            arm_q <= PKT_ONGOING & RX_PORT_TRUNC_ON & CODE_FILTER_PASS;
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    // Modulo 64 falls out of the 6-bit compare
    sequence s_port_time;
        RX_CODE_VALID && !RX_CODE_AUX && RX_CODE[7:6] == 2'h0 && RX_CODE[5:0] == TIME_COUNT + 6'h01;
    endsequence
    property p_time_fwd;
        s_port_time |=> TX_CODE_VALID && TX_CODE == $past(RX_CODE);
    endproperty
    property p_count_follow;
        s_port_time |=> TIME_COUNT == TX_CODE[5:0];
    endproperty
    property p_count_cause;
        !$stable(TIME_COUNT) |-> $past(RX_CODE_VALID);
    endproperty
    property p_irq_flags;
        TX_CODE_VALID && TX_CODE[7:6] != 2'h0 |-> TX_CODE[7:6] == 2'h2;
    endproperty
    property p_no_echo;
        RX_CODE_VALID && RX_CODE_AUX |=> !(AUX_TX_VALID && AUX_TX_CODE == $past(RX_CODE));
    endproperty
    property p_spill_cause;
        PKT_SPILL != 4'h0 |-> (PKT_SPILL & ~arm_q) == 4'h0 && $past(RX_CODE_VALID);
    endproperty
    property p_discard;
        PKT_DISCARD |-> $past(TABLE_MEM_ERR);
    endproperty
    property p_fifo_spill;
        FIFO_SPILL |-> $past(FIFO_MEM_ERR);
    endproperty
    a_time_fwd: assert property (p_time_fwd) else $error("time code not forwarded");
    a_count_follow: assert property (p_count_follow) else $error("time count not updated");
    a_count_cause: assert property (p_count_cause) else $error("time count moved alone");
    a_irq_flags: assert property (p_irq_flags) else $error("bad code flags");
    a_no_echo: assert property (p_no_echo) else $error("code echoed to aux");
    a_spill_cause: assert property (p_spill_cause) else $error("spill without cause");
    a_discard: assert property (p_discard) else $error("discard without cause");
    a_fifo_spill: assert property (p_fifo_spill) else $error("fifo spill without cause");
endmodule
bind rdit_top rdit_monitor u_mon (
    .REF_CLK(REF_CLK), .RST_B(RST_B), .RX_CODE_VALID(RX_CODE_VALID),
    .RX_CODE(RX_CODE), .RX_CODE_AUX(RX_CODE_AUX), .RX_PORT_TRUNC_ON(RX_PORT_TRUNC_ON),
    .PKT_ONGOING(PKT_ONGOING), .CODE_FILTER_PASS(CODE_FILTER_PASS), .TABLE_MEM_ERR(TABLE_MEM_ERR),
    .FIFO_MEM_ERR(FIFO_MEM_ERR), .TX_CODE_VALID(TX_CODE_VALID), .TX_CODE(TX_CODE),
    .AUX_TX_VALID(AUX_TX_VALID), .AUX_TX_CODE(AUX_TX_CODE), .TIME_COUNT(TIME_COUNT),
    .PKT_SPILL(PKT_SPILL), .PKT_DISCARD(PKT_DISCARD), .FIFO_SPILL(FIFO_SPILL));
`default_nettype wire

//--- bench/rdit_far_node.sv
`timescale 1ns/1ps
`default_nettype none
module rdit_far_node (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       stall,
    input  wire logic       valid,
    input  wire logic [7:0] code,
    output var  logic       ready,
    output var  int         n_irq,
    output var  int         n_time,
    output var  logic [7:0] last
);
    // ----------------------------------------
    // Remote node: sink with optional stall
    // ----------------------------------------
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ready <= 1'b0;
            n_irq <= 0;
            n_time <= 0;
            last <= 8'h00;
        end else begin
            ready <= !stall;
            if (valid) begin
                last <= code;
                if (code[7:6] == 2'h2)
                    n_irq <= n_irq + 1;
                else if (code[7:6] == 2'h0)
                    n_time <= n_time + 1;
            end
        end
    end
endmodule
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "rdit_defines.vh"
module testbench;
    // ----------------------------------------
    // Stimulus, sinks and checks
    // ----------------------------------------
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        rwr = 1'b0;
    logic        rrd = 1'b0;
    logic        cv = 1'b0;
    logic [7:0]  code = 8'h00;
    logic        aux = 1'b0;
    logic [3:0]  trunc = 4'h0;
    logic [3:0]  ong = 4'h0;
    logic [3:0]  fpass = 4'h0;
    logic [23:0] err = 24'h0;
    logic        tmerr = 1'b0;
    logic        fmerr = 1'b0;
    logic        stall = 1'b0;
    logic        ready, txv, auxv, disc, fsp;
    logic [7:0]  txc, auxc, last;
    logic [5:0]  tcnt;
    logic [3:0]  spill;
    logic [31:0] rdata, v;
    int          n_irq, n_time;
    int          n_aux = 0, n_spill = 0, n_disc = 0, n_fs = 0;
    int          n_fail = 0;
    int          samples_checked = 0;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        n_aux += auxv;
        n_spill += spill[0];
        n_disc += disc;
        n_fs += fsp;
    end
    rdit_top DUT (.REF_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(rwr), .REG_RD(rrd), .REG_RDATA(rdata), .RX_CODE_VALID(cv), .RX_CODE(code),
        .RX_CODE_AUX(aux), .RX_PORT_TRUNC_ON(trunc), .PKT_ONGOING(ong), .CODE_FILTER_PASS(fpass),
        .ERR_EVENT(err), .RUN_ENTER(4'h0), .TABLE_MEM_ERR(tmerr), .FIFO_MEM_ERR(fmerr),
        .TX_CODE_READY(ready), .TX_CODE_VALID(txv), .TX_CODE(txc), .AUX_TX_VALID(auxv),
        .AUX_TX_CODE(auxc), .TIME_COUNT(tcnt), .PKT_SPILL(spill), .PKT_DISCARD(disc),
        .FIFO_SPILL(fsp));
    rdit_far_node u_far (.clk(clk), .rst_b(rst_b), .stall(stall), .valid(txv), .code(txc),
        .ready(ready), .n_irq(n_irq), .n_time(n_time), .last(last));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rwr <= 1'b1;
        @(posedge clk);
        rwr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rrd <= 1'b1;
        @(posedge clk);
        rrd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic send(input logic [7:0] c, input logic a);
        @(posedge clk);
        code <= c;
        aux <= a;
        cv <= 1'b1;
        @(posedge clk);
        cv <= 1'b0;
        tick(2);
    endtask
    // Memory errors ride in the top two bits
    task automatic fire(input logic [25:0] e);
        @(posedge clk);
        {fmerr, tmerr, err} <= e;
        @(posedge clk);
        {fmerr, tmerr, err} <= 26'h0;
        tick(2);
    endtask
    task automatic t_irq;
        reg_wr(`RDIT_OFF_ACK_WAIT, 32'h0);
        send(8'h83, 1'b0);
        chk(last, 8'h83);
        reg_rd(`RDIT_OFF_STATE_LOW);
        chk(v, 32'h8);
        send(8'h83, 1'b0);
        chk(n_irq, 1);
        send(8'hA3, 1'b0);
        chk(n_irq, 2);
        reg_rd(`RDIT_OFF_STATE_LOW);
        chk(v, 32'h0);
    endtask
    task automatic t_timer;
        reg_wr(`RDIT_OFF_ACK_WAIT, 32'h14);
        send(8'h85, 1'b0);
        reg_rd(`RDIT_OFF_STATE_LOW);
        chk(v, 32'h20);
        tick(20);
        reg_rd(`RDIT_OFF_STATE_LOW);
        chk(v, 32'h0);
    endtask
    task automatic t_guard;
        reg_wr(`RDIT_OFF_ACK_WAIT, 32'h0);
        reg_wr(`RDIT_OFF_CHG_GUARD, 32'h28);
        reg_wr(`RDIT_OFF_RTR_CFG, 32'h1);
        send(8'h87, 1'b0);
        send(8'hA7, 1'b0);
        chk(n_irq, 4);
        reg_rd(`RDIT_OFF_STATE_LOW);
        chk(v, 32'h80);
        tick(40);
        send(8'hA7, 1'b0);
        send(8'h87, 1'b0);
        chk(n_irq, 5);
        reg_wr(`RDIT_OFF_RTR_CFG, 32'h0);
    endtask
    task automatic t_time;
        send(8'h01, 1'b1);
        chk(tcnt, 6'h00);
        reg_wr(`RDIT_OFF_RTR_CFG, 32'h4);
        send(8'h01, 1'b1);
        chk({tcnt, n_time[7:0], n_aux[7:0]}, 22'h01_01_00);
        trunc <= 4'h1;
        ong <= 4'h1;
        fpass <= 4'h1;
        send(8'h02, 1'b0);
        chk({n_aux[7:0], n_spill[7:0]}, 16'h0101);
        send(8'h07, 1'b0);
        chk({n_time[7:0], n_spill[7:0]}, 16'h0201);
    endtask
    task automatic t_gen;
        reg_wr(`RDIT_OFF_PORT_MASK, 32'h1);
        reg_wr(`RDIT_OFF_TYPE_MASK, 32'h3E);
        reg_wr(`RDIT_OFF_GEN_CTRL, 32'h0901);
        fire(26'h41);
        tick(10);
        chk(n_irq, 5);
        reg_wr(`RDIT_OFF_PENDING, 32'hFFFFFFFF);
        reg_wr(`RDIT_OFF_TYPE_MASK, 32'h3F);
        stall <= 1'b1;
        fire(26'h1);
        tick(10);
        chk(n_irq, 5);
        stall <= 1'b0;
        tick(10);
        chk({n_irq[7:0], last}, 16'h0689);
        send(8'hA9, 1'b0);
        tick(10);
        chk(n_irq, 7);
        reg_wr(`RDIT_OFF_PENDING, 32'hFFFFFFFF);
        stall <= 1'b1;
        fire(26'h1);
        reg_wr(`RDIT_OFF_PENDING, 32'hFFFFFFFF);
        stall <= 1'b0;
        tick(10);
        chk(n_irq, 7);
        reg_wr(`RDIT_OFF_HOLDOFF, 32'h14);
        reg_wr(`RDIT_OFF_GEN_CTRL, 32'h090F);
        fire(26'h1);
        send(8'hA9, 1'b0);
        reg_rd(`RDIT_OFF_PENDING);
        chk({n_irq[7:0], v[7:0]}, 16'h0900);
        fire(26'h1);
        chk(n_irq, 9);
        tick(20);
        chk(n_irq, 10);
        reg_wr(`RDIT_OFF_GEN_CTRL, 32'h0);
        reg_wr(`RDIT_OFF_PENDING, 32'hFFFFFFFF);
    endtask
    task automatic t_err;
        fire(26'h8);
        tick(20);
        reg_rd(`RDIT_OFF_PORT_STS0);
        chk(v & 32'h8, 32'h8);
        reg_wr(`RDIT_OFF_PORT_STS0, 32'hFFFFFFFF);
        reg_rd(`RDIT_OFF_PORT_STS0);
        chk(v, 32'h0);
        fire(26'h1000000);
        chk(n_disc, 1);
        fire(26'h2000000);
        chk(n_fs, 0);
        reg_wr(`RDIT_OFF_RTR_CFG, 32'h10);
        fire(26'h2000000);
        chk(n_fs, 1);
    endtask
    task automatic wrap_up;
        if (n_fail == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_irq;
        t_timer;
        t_guard;
        t_time;
        t_gen;
        t_err;
        wrap_up;
    end
    // Whole run is well under 1000 cycles
    initial begin
        #100000;
        n_fail++;
        wrap_up;
    end
endmodule
`default_nettype wire
